// ===== logic/tag_cfg_pkg.sv
package tag_cfg_pkg;
   // Command framing
   localparam logic [15:0] TOGGLE_OPCODE = 16'hE007;
   localparam logic [6:0] CMD_BITS = 7'h48;
   localparam logic [6:0] CNT_SAT = 7'h7F;
   localparam int OPC_MSB = 71;
   localparam int OPC_LSB = 56;
   localparam int DATA_MSB = 47;
   localparam int DATA_LSB = 32;
   localparam int HDL_MSB = 31;
   localparam int HDL_LSB = 16;
   // CRC-16 of the air protocol
   localparam logic [15:0] CRC_PRESET = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_RESIDUE = 16'h1D0F;
   localparam logic [4:0] CRC_BITS = 5'h10;
   // Reply framing
   localparam logic [5:0] REPLY_PAYLOAD_BITS = 6'h21;
   localparam logic [5:0] ERR_PAYLOAD_BITS = 6'h19;
   localparam logic [7:0] ERROR_CODE = 8'h0F;
   // Feature configuration word
   localparam logic [15:0] CFG_ADDR = 16'h0200;
   localparam int BIT_TAMPER = 0;
   localparam int BIT_SUPPLY = 1;
   localparam int BIT_INVERT = 4;
   localparam int BIT_TRANSP = 5;
   localparam int BIT_RAWMODE = 6;
   localparam int BIT_COND_RR = 7;
   localparam int BIT_COND_SHORT = 8;
   localparam int BIT_DIG_OUT = 10;
   localparam int BIT_RANGE_RED = 11;
   localparam int UPD_LSB = 4;
   localparam logic [15:0] RSV_MASK = 16'h000C;
   localparam logic [15:0] TOGGLE_MASK = 16'hFFF0;
   localparam logic [2:0] TEMP_RESET = 3'h0;
   localparam logic [8:0] PERM_RESET = 9'h000;

   typedef enum logic [2:0]
   {
      TAG_READY,
      TAG_ARBITRATE,
      TAG_REPLY,
      TAG_ACKNOWLEDGED,
      TAG_OPEN,
      TAG_SECURED,
      TAG_KILLED
   } tag_state_e;
endpackage

// ===== logic/cfg_update_if.sv
`timescale 1ns/100ps
interface cfg_update_if;
   logic [15:0] word;
   logic updReq;
   logic [11:0] updBits;
   logic busy;
   logic done;
   logic fail;

   modport ctrl
   (
      input word,
      input busy,
      input done,
      input fail,
      output updReq,
      output updBits
   );
   modport store
   (
      output word,
      output busy,
      output done,
      output fail,
      input updReq,
      input updBits
   );
endinterface

// ===== logic/crc16_serial.sv
`timescale 1ns/100ps
module crc16_serial
(
   input wire logic clock,
   input wire logic rst,
   input wire logic clear,
   input wire logic enable,
   input wire logic dataBit,
   output logic [15:0] crc
);
   import tag_cfg_pkg::*;

   logic [15:0] crc_q;
   logic [15:0] crc_d;
   logic fb;

   // Bit-serial shift, most significant bit first
   always_comb
   begin
      fb = dataBit ^ crc_q[15];
      crc_d = crc_q;
      if (clear)
      begin
         crc_d = CRC_PRESET;
      end
      else if (enable)
      begin
         crc_d = {crc_q[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         crc_q <= CRC_PRESET;
      end
      else
      begin
         crc_q <= crc_d;
      end
   end

   assign crc = crc_q;
endmodule

// ===== logic/config_word_store.sv
`timescale 1ns/100ps
module config_word_store
(
   input wire logic clock,
   input wire logic rst,
   cfg_update_if.store cfg,
   input wire logic supplyPad,
   input wire logic linkClosed,
   input wire logic [8:0] nvmImage,
   input wire logic nvmLoad,
   output logic nvmWrReq,
   output logic [8:0] nvmWrData,
   input wire logic nvmDone,
   input wire logic nvmFail
);
   import tag_cfg_pkg::*;

   typedef enum logic [1:0] {S_IDLE, S_WAIT, S_DONE, S_FAIL} store_state_e;

   store_state_e st_q;
   store_state_e st_d;
   logic [2:0] temp_q;
   logic [2:0] temp_d;
   logic [8:0] perm_q;
   logic [8:0] perm_d;
   logic [8:0] pend_q;
   logic [8:0] pend_d;

   // Temporary bits apply at once; permanent bits only after the NVM confirms
   always_comb
   begin
      st_d = st_q;
      temp_d = temp_q;
      perm_d = perm_q;
      pend_d = pend_q;
      unique case (st_q)
         S_IDLE:
         begin
            if (nvmLoad)
            begin
               perm_d = nvmImage;
            end
            if (cfg.updReq)
            begin
               temp_d = cfg.updBits[2:0];
               if (cfg.updBits[11:3] != perm_q)
               begin
                  pend_d = cfg.updBits[11:3];
                  st_d = S_WAIT;
               end
               else
               begin
                  st_d = S_DONE;
               end
            end
         end
         S_WAIT:
         begin
            if (nvmDone)
            begin
               perm_d = pend_q;
               st_d = S_DONE;
            end
            else if (nvmFail)
            begin
               st_d = S_FAIL;
            end
         end
         S_DONE: st_d = S_IDLE;
         S_FAIL: st_d = S_IDLE;
      endcase
   end

   // Power-up reset clears the temporary bits; NVM image loads afterwards
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         st_q <= S_IDLE;
         temp_q <= TEMP_RESET;
         perm_q <= PERM_RESET;
         pend_q <= PERM_RESET;
      end
      else
      begin
         st_q <= st_d;
         temp_q <= temp_d;
         perm_q <= perm_d;
         pend_q <= pend_d;
      end
   end

   // Indicators are live pad state, reserved bits read as zero
   assign cfg.word = {perm_q, temp_q, 2'b00, supplyPad, ~linkClosed};
   assign cfg.busy = (st_q != S_IDLE);
   assign cfg.done = (st_q == S_DONE);
   assign cfg.fail = (st_q == S_FAIL);
   assign nvmWrReq = (st_q == S_WAIT);
   assign nvmWrData = pend_q;
endmodule

// ===== logic/tag_feature_config_command.sv
`timescale 1ns/100ps
module tag_feature_config_command
(
   input wire logic clock,
   input wire logic rst,
   input tag_cfg_pkg::tag_state_e tagState,
   input wire logic frameSyncSeen,
   input wire logic rxBit,
   input wire logic rxBitValid,
   input wire logic frameEnd,
   input wire logic priorReqRn,
   input wire logic [15:0] lastRn16,
   input wire logic [15:0] handle,
   input wire logic accessPwdZero,
   input wire logic epcLocked,
   input wire logic supplyPad,
   input wire logic linkClosed,
   input wire logic demodIn,
   input wire logic syncStrip,
   input wire logic [8:0] nvmImage,
   input wire logic nvmLoad,
   output logic nvmWrReq,
   output logic [8:0] nvmWrData,
   input wire logic nvmDone,
   input wire logic nvmFail,
   input wire logic [15:0] memAddr,
   input wire logic memRead,
   input wire logic memWrite,
   input wire logic [15:0] memWdata,
   output logic [15:0] memRdata,
   output logic memRdValid,
   output logic toArbitrate,
   output logic txStart,
   output logic txExtPreamble,
   output logic txBit,
   output logic txValid,
   input wire logic txReady,
   output logic txLast,
   output logic outPin,
   output logic reducedSensitivity,
   output logic holdSessionFlags
);
   import tag_cfg_pkg::*;

   typedef enum logic [2:0] {ST_IDLE, ST_RECV, ST_EVAL, ST_WAIT_NV, ST_LOAD, ST_SEND,
      ST_CRCLOAD, ST_SENDCRC} cmd_state_e;

   cfg_update_if cfg ();

   cmd_state_e st_q;
   cmd_state_e st_d;
   logic [71:0] rxShift_q;
   logic [71:0] rxShift_d;
   logic [6:0] rxCnt_q;
   logic [6:0] rxCnt_d;
   logic isErr_q;
   logic isErr_d;
   logic [32:0] txShift_q;
   logic [32:0] txShift_d;
   logic [5:0] payLeft_q;
   logic [5:0] payLeft_d;
   logic [4:0] crcLeft_q;
   logic [4:0] crcLeft_d;
   logic [15:0] crcSh_q;
   logic [15:0] crcSh_d;
   logic [15:0] rdData_q;
   logic [15:0] rdData_d;
   logic rdValid_q;
   logic rdValid_d;
   logic demodPrev_q;
   logic togglePin_q;
   logic togglePin_d;
   logic outPin_q;
   logic outPin_d;
   logic [15:0] rxCrc;
   logic [15:0] txCrc;
   logic rxCrcEn;
   logic txCrcEn;
   logic [15:0] mask;
   logic [15:0] effMask;
   logic frameOk;
   logic crcOk;
   logic handleOk;
   logic cfgHit;
   logic txFire;

   config_word_store u_store
   (
      .clock(clock),
      .rst(rst),
      .cfg(cfg.store),
      .supplyPad(supplyPad),
      .linkClosed(linkClosed),
      .nvmImage(nvmImage),
      .nvmLoad(nvmLoad),
      .nvmWrReq(nvmWrReq),
      .nvmWrData(nvmWrData),
      .nvmDone(nvmDone),
      .nvmFail(nvmFail)
   );

   // Receive check runs over every bit of the frame, opcode through handle plus CRC
   assign rxCrcEn = rxBitValid && (st_q == ST_RECV);
   crc16_serial u_rx_crc
   (
      .clock(clock),
      .rst(rst),
      .clear(frameSyncSeen),
      .enable(rxCrcEn),
      .dataBit(rxBit),
      .crc(rxCrc)
   );

   assign txFire = txValid && txReady;
   assign txCrcEn = txFire && (st_q == ST_SEND);
   crc16_serial u_tx_crc
   (
      .clock(clock),
      .rst(rst),
      .clear(st_q == ST_LOAD),
      .enable(txCrcEn),
      .dataBit(txShift_q[32]),
      .crc(txCrc)
   );

   // Decoded command fields
   assign frameOk = (rxCnt_q == CMD_BITS) && (rxShift_q[OPC_MSB:OPC_LSB] == TOGGLE_OPCODE);
   assign crcOk = (rxCrc == CRC_RESIDUE);
   assign handleOk = (rxShift_q[HDL_MSB:HDL_LSB] == handle);
   assign mask = rxShift_q[DATA_MSB:DATA_LSB] ^ lastRn16;
   // Indicator bits and open/zero-password cases never reach the word
   assign effMask = ((tagState == TAG_OPEN) || accessPwdZero) ? 16'h0000
      : (mask & TOGGLE_MASK);
   assign cfgHit = (memAddr == CFG_ADDR);

   // Command sequencer: receive, judge, update, answer
   always_comb
   begin
      st_d = st_q;
      rxShift_d = rxShift_q;
      rxCnt_d = rxCnt_q;
      isErr_d = isErr_q;
      txShift_d = txShift_q;
      payLeft_d = payLeft_q;
      crcLeft_d = crcLeft_q;
      crcSh_d = crcSh_q;
      cfg.updReq = 1'b0;
      cfg.updBits = cfg.word[15:UPD_LSB];
      toArbitrate = 1'b0;
      txStart = 1'b0;
      txValid = 1'b0;
      txLast = 1'b0;
      // A frame without a preceding frame-sync never enters the receive state
      if (frameSyncSeen && (st_q == ST_IDLE || st_q == ST_RECV))
      begin
         st_d = ST_RECV;
         rxCnt_d = 7'h00;
      end
      unique case (st_q)
         ST_IDLE:
         begin
            // Standard WRITE reaches the word only while the bank is unlocked
            if (!frameSyncSeen && memWrite && cfgHit && !epcLocked && !cfg.busy)
            begin
               cfg.updReq = 1'b1;
               cfg.updBits = memWdata[15:UPD_LSB];
            end
         end
         ST_RECV:
         begin
            if (!frameSyncSeen && rxBitValid)
            begin
               rxShift_d = {rxShift_q[70:0], rxBit};
               rxCnt_d = (rxCnt_q == CNT_SAT) ? CNT_SAT : rxCnt_q + 7'h01;
            end
            if (!frameSyncSeen && frameEnd)
            begin
               st_d = ST_EVAL;
            end
         end
         ST_EVAL:
         begin
            st_d = ST_IDLE;
            if (frameOk)
            begin
               unique case (tagState)
                  TAG_READY, TAG_KILLED: st_d = ST_IDLE;
                  TAG_ARBITRATE, TAG_REPLY, TAG_ACKNOWLEDGED: toArbitrate = 1'b1;
                  TAG_OPEN, TAG_SECURED:
                  begin
                     if (crcOk && handleOk && priorReqRn && ((mask & RSV_MASK) == 16'h0000)
                        && !cfg.busy)
                     begin
                        isErr_d = 1'b0;
                        if (effMask == 16'h0000)
                        begin
                           st_d = ST_LOAD;
                        end
                        else
                        begin
                           cfg.updReq = 1'b1;
                           cfg.updBits = cfg.word[15:UPD_LSB] ^ effMask[15:UPD_LSB];
                           st_d = ST_WAIT_NV;
                        end
                     end
                  end
                  default: st_d = ST_IDLE;
               endcase
            end
         end
         ST_WAIT_NV:
         begin
            if (cfg.done)
            begin
               st_d = ST_LOAD;
            end
            else if (cfg.fail)
            begin
               isErr_d = 1'b1;
               st_d = ST_LOAD;
            end
         end
         ST_LOAD:
         begin
            txStart = 1'b1;
            crcLeft_d = CRC_BITS;
            if (isErr_q)
            begin
               txShift_d = {1'b1, ERROR_CODE, handle, 8'h00};
               payLeft_d = ERR_PAYLOAD_BITS;
            end
            else
            begin
               txShift_d = {1'b0, cfg.word, handle};
               payLeft_d = REPLY_PAYLOAD_BITS;
            end
            st_d = ST_SEND;
         end
         ST_SEND:
         begin
            txValid = 1'b1;
            if (txFire)
            begin
               txShift_d = {txShift_q[31:0], 1'b0};
               payLeft_d = payLeft_q - 6'h01;
               if (payLeft_q == 6'h01)
               begin
                  st_d = ST_CRCLOAD;
               end
            end
         end
         ST_CRCLOAD:
         begin
            // One idle cycle lets the generator absorb the final payload bit
            crcSh_d = ~txCrc;
            st_d = ST_SENDCRC;
         end
         ST_SENDCRC:
         begin
            txValid = 1'b1;
            txLast = (crcLeft_q == 5'h01);
            if (txFire)
            begin
               crcSh_d = {crcSh_q[14:0], 1'b0};
               crcLeft_d = crcLeft_q - 5'h01;
               if (crcLeft_q == 5'h01)
               begin
                  st_d = ST_IDLE;
               end
            end
         end
      endcase
   end

   assign txBit = (st_q == ST_SENDCRC) ? crcSh_q[15] : txShift_q[32];
   assign txExtPreamble = !isErr_q;

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         st_q <= ST_IDLE;
         rxShift_q <= '0;
         rxCnt_q <= 7'h00;
         isErr_q <= 1'b0;
         txShift_q <= '0;
         payLeft_q <= 6'h00;
         crcLeft_q <= 5'h00;
         crcSh_q <= 16'h0000;
      end
      else
      begin
         st_q <= st_d;
         rxShift_q <= rxShift_d;
         rxCnt_q <= rxCnt_d;
         isErr_q <= isErr_d;
         txShift_q <= txShift_d;
         payLeft_q <= payLeft_d;
         crcLeft_q <= crcLeft_d;
         crcSh_q <= crcSh_d;
      end
   end

   // Memory READ of the word, answered one cycle later
   always_comb
   begin
      rdValid_d = memRead && cfgHit;
      rdData_d = rdData_q;
      if (memRead && cfgHit)
      begin
         rdData_d = cfg.word;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         rdData_q <= 16'h0000;
         rdValid_q <= 1'b0;
      end
      else
      begin
         rdData_q <= rdData_d;
         rdValid_q <= rdValid_d;
      end
   end

   assign memRdata = rdData_q;
   assign memRdValid = rdValid_q;

   // Output pin: switch level, or transparent forwarding of the air signal
   always_comb
   begin
      togglePin_d = togglePin_q;
      if (demodIn && !demodPrev_q && !syncStrip)
      begin
         togglePin_d = ~togglePin_q;
      end
      if (!cfg.word[BIT_TRANSP])
      begin
         outPin_d = cfg.word[BIT_DIG_OUT] ^ cfg.word[BIT_INVERT];
      end
      else if (cfg.word[BIT_RAWMODE])
      begin
         outPin_d = demodIn;
      end
      else
      begin
         outPin_d = togglePin_q;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         demodPrev_q <= 1'b0;
         togglePin_q <= 1'b0;
         outPin_q <= 1'b0;
      end
      else
      begin
         demodPrev_q <= demodIn;
         togglePin_q <= togglePin_d;
         outPin_q <= outPin_d;
      end
   end

   assign outPin = outPin_q;

   // Plain reduction is unconditional; conditional form waits on the pad link
   assign reducedSensitivity = cfg.word[BIT_RANGE_RED] && (!cfg.word[BIT_COND_RR]
      || (cfg.word[BIT_COND_SHORT] ? linkClosed : !linkClosed));

   // Without power-on reset the session logic must freeze S0, S2, S3 and SL
   assign holdSessionFlags = supplyPad;
endmodule

// ===== verification/tag_feature_config_command_assertions.sv
`timescale 1ns/100ps
module tag_feature_config_command_assertions
(
   input wire logic clock,
   input wire logic rst,
   input tag_cfg_pkg::tag_state_e tagState,
   input wire logic supplyPad,
   input wire logic epcLocked,
   input wire logic memRead,
   input wire logic [15:0] memAddr,
   input wire logic [15:0] memRdata,
   input wire logic memRdValid,
   input wire logic nvmWrReq,
   input wire logic toArbitrate,
   input wire logic txStart,
   input wire logic txExtPreamble,
   input wire logic txBit,
   input wire logic txValid,
   input wire logic txReady,
   input wire logic txLast,
   input wire logic holdSessionFlags
);
   import tag_cfg_pkg::*;
   logic [6:0] bitCnt_q;
   logic [6:0] bitCnt_d;
   // Counts accepted reply bits so the frame length is judged at its last bit
   always_comb
   begin
      bitCnt_d = txStart ? 7'h00 : bitCnt_q + {6'h00, txValid & txReady};
   end
   always_ff @(posedge clock)
   begin
      bitCnt_q <= rst ? 7'h00 : bitCnt_d;
   end
   default clocking @(posedge clock);
   endclocking
   default disable iff (rst);
   sequence s_readHit;
      memRead && memAddr == CFG_ADDR;
   endsequence
   sequence s_answer;
      memRdValid && memRdata[3:2] == 2'h0;
   endsequence
   a_read_answer: assert property (s_readHit |=> s_answer)
      else $error("config word read not answered next cycle");
   a_read_cause: assert property (memRdValid |-> $past(memRead && memAddr == CFG_ADDR))
      else $error("read answer without a matching read");
   a_supply_hold: assert property (holdSessionFlags == supplyPad)
      else $error("session flag hold does not follow supply pad");
   a_arb_state: assert property (toArbitrate |-> tagState inside {TAG_ARBITRATE, TAG_REPLY, TAG_ACKNOWLEDGED})
      else $error("fallback to arbitrate from wrong state");
   a_dead_silent: assert property (tagState inside {TAG_READY, TAG_KILLED} |-> !txStart && !toArbitrate)
      else $error("reaction in ready or killed state");
   a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txBit))
      else $error("reply bit not held while stalled");
   a_reply_len: assert property (txValid && txReady && txLast && txExtPreamble |-> bitCnt_q == 7'h30)
      else $error("success reply length is not 49 bits");
   a_start_valid: assert property (txStart |=> txValid)
      else $error("reply start not followed by data");
   a_open_no_store: assert property (tagState == TAG_OPEN && epcLocked |-> !$rose(nvmWrReq))
      else $error("store write in open state");
endmodule
bind tag_feature_config_command tag_feature_config_command_assertions chk
(
   .clock, .rst, .tagState, .supplyPad, .epcLocked, .memRead, .memAddr, .memRdata, .memRdValid,
   .nvmWrReq, .toArbitrate, .txStart, .txExtPreamble, .txBit, .txValid, .txReady, .txLast,
   .holdSessionFlags
);

// ===== verification/interrogator_model.sv
`timescale 1ns/100ps
module interrogator_model
(
   input wire logic clock,
   output logic frameSyncSeen,
   output logic rxBit,
   output logic rxBitValid,
   output logic frameEnd,
   output logic txReady,
   input wire logic txStart,
   input wire logic txExtPreamble,
   input wire logic txBit,
   input wire logic txValid,
   input wire logic txLast
);
   import tag_cfg_pkg::*;
   logic slow = 1'h0;
   initial
   begin
      frameSyncSeen = 1'h0;
      rxBit = 1'h0;
      rxBitValid = 1'h0;
      frameEnd = 1'h0;
      txReady = 1'h1;
   end
   // Stalled mode drops ready every other cycle so held reply bits get exercised
   always @(negedge clock)
      txReady <= slow ? ~txReady : 1'h1;
   // Serial CRC of the air link, MSB first
   function automatic logic [15:0] crcOf(input logic [71:0] v, input int n);
      logic [15:0] c;
      c = CRC_PRESET;
      for (int i = n - 1; i >= 0; i--)
         c = {c[14:0], 1'h0} ^ ((c[15] ^ v[i]) ? CRC_POLY : 16'h0000);
      return c;
   endfunction
   // Frame-sync, then opcode, zero field, data, handle and inverted CRC
   task automatic send(input logic [15:0] data, input logic [15:0] hdl, input logic sync,
      input logic [15:0] flip);
      logic [71:0] f;
      f = {TOGGLE_OPCODE, 8'h00, data, hdl, 16'h0000};
      f[15:0] = ~crcOf(f >> 16, 56) ^ flip;
      @(negedge clock);
      frameSyncSeen = sync;
      @(negedge clock);
      frameSyncSeen = 1'h0;
      for (int i = 71; i >= 0; i--)
      begin
         rxBit = f[i];
         rxBitValid = 1'h1;
         @(negedge clock);
      end
      rxBitValid = 1'h0;
      rxBit = ~rxBit; // Line no longer carries the last bit
      frameEnd = 1'h1;
      @(negedge clock);
      frameEnd = 1'h0;
   endtask
   // Collects one reply; got stays low if none starts within the wait
   task automatic getReply(output logic got, output logic [48:0] r, output logic pre);
      int n;
      got = 1'h0;
      r = '0;
      pre = 1'h0;
      n = 0;
      for (int w = 0; w < 400 && !got; w++)
      begin
         @(negedge clock) #1; // Settled values of the coming edge
         got = txStart;
         pre = txExtPreamble;
      end
      for (int w = 0; got && n < 60 && w < 200; w++)
      begin
         @(negedge clock) #1;
         if (txValid && txReady)
         begin
            r = {r[47:0], txBit};
            n++;
            if (txLast)
               break;
         end
      end
   endtask
endmodule

// ===== verification/test_tag_feature_config_command.sv
`timescale 1ns/100ps
module test_tag_feature_config_command;
   import tag_cfg_pkg::*;
   logic clock, rst, frameSyncSeen, rxBit, rxBitValid, frameEnd, priorReqRn, accessPwdZero;
   logic epcLocked, supplyPad, linkClosed, nvmLoad, nvmWrReq, memRead, memWrite, memRdValid;
   logic toArbitrate, txStart, txExtPreamble, txBit, txValid, txReady, txLast, outPin;
   logic reducedSensitivity, holdSessionFlags, nvmBad, demodIn;
   logic nvmDone = 1'h0;
   logic nvmFail = 1'h0;
   logic [15:0] lastRn16, handle, memAddr, memWdata, memRdata, expWord;
   logic [8:0] nvmImage, nvmWrData;
   tag_state_e tagState;
   int err_total, comparisons, arbSeen, nvmCnt;
   tag_feature_config_command DUT
   (
      .clock, .rst, .tagState, .frameSyncSeen, .rxBit, .rxBitValid, .frameEnd, .priorReqRn,
      .lastRn16, .handle, .accessPwdZero, .epcLocked, .supplyPad, .linkClosed,
      .demodIn, .syncStrip(1'h0), .nvmImage, .nvmLoad, .nvmWrReq, .nvmWrData, .nvmDone,
      .nvmFail, .memAddr, .memRead, .memWrite, .memWdata, .memRdata, .memRdValid, .toArbitrate,
      .txStart, .txExtPreamble, .txBit, .txValid, .txReady, .txLast, .outPin,
      .reducedSensitivity, .holdSessionFlags
   );
   interrogator_model IM
   (
      .clock, .frameSyncSeen, .rxBit, .rxBitValid, .frameEnd, .txReady, .txStart,
      .txExtPreamble, .txBit, .txValid, .txLast
   );
   initial
   begin
      clock = 1'h0;
      forever #5 clock = ~clock;
   end
   // Store answers each write request after a few cycles, or fails on demand
   always @(negedge clock)
   begin
      nvmCnt <= nvmWrReq ? nvmCnt + 1 : 0;
      nvmDone <= nvmWrReq && nvmCnt == 5 && !nvmBad;
      nvmFail <= nvmWrReq && nvmCnt == 5 && nvmBad;
   end
   always @(negedge clock)
      if (toArbitrate)
         arbSeen <= arbSeen + 1;
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic ok);
      repeat (3) @(negedge clock);
      memAddr = a;
      memRead = 1'h1;
      @(negedge clock);
      memRead = 1'h0;
      ok = memRdValid;
      d = memRdata;
   endtask
   task automatic wr(input logic lock, input logic [15:0] v);
      epcLocked = lock;
      @(negedge clock);
      memAddr = CFG_ADDR;
      memWdata = v;
      memWrite = 1'h1;
      @(negedge clock);
      memWrite = 1'h0;
      repeat (12) @(negedge clock);
      epcLocked = 1'h1;
   endtask
   task automatic cmd(input logic [15:0] data, input logic [15:0] hdl, input logic sync,
      input logic [15:0] flip, output logic got, output logic [48:0] r, output logic pre);
      fork
         IM.send(data, hdl, sync, flip);
         IM.getReply(got, r, pre);
      join
   endtask
   task automatic expectReply(input logic [15:0] mask, input logic [15:0] w);
      logic got, pre;
      logic [48:0] r;
      cmd(mask ^ lastRn16, handle, 1'h1, 16'h0000, got, r, pre);
      check("reply seen", 16'h0001, {15'h0000, got});
      check("header", 16'h0000, {15'h0000, r[48]});
      check("word", w, r[47:32]);
      check("handle", handle, r[31:16]);
      check("crc", ~IM.crcOf({39'h0, r[48:16]}, 33), r[15:0]);
      check("ext preamble", 16'h0001, {15'h0000, pre});
   endtask
   task automatic t_power;
      logic [15:0] d;
      logic ok;
      expWord = {nvmImage, 5'h00, supplyPad, ~linkClosed};
      rd(CFG_ADDR, d, ok);
      check("read valid", 16'h0001, {15'h0000, ok});
      check("power-up word", expWord, d);
      check("pin", {15'h0000, expWord[BIT_DIG_OUT]}, {15'h0000, outPin});
      rd(16'h0201, d, ok);
      check("stray read", 16'h0000, {15'h0000, ok});
      supplyPad = 1'h0;
      linkClosed = 1'h0;
      rd(CFG_ADDR, d, ok);
      check("indicators", expWord ^ 16'h0003, d);
      supplyPad = 1'h1;
      linkClosed = 1'h1;
      wr(1'h0, expWord ^ 16'h001F); // Low nibble must be ignored
      wr(1'h1, expWord);
      rd(CFG_ADDR, d, ok);
      check("unlocked write", expWord ^ 16'h0010, d);
      check("pin inverted", {15'h0000, ~expWord[BIT_DIG_OUT]}, {15'h0000, outPin});
      demodIn = 1'h1; // Rising edge toggles the pin
      wr(1'h0, expWord ^ 16'h0030);
      check("data pin", 16'h0001, {15'h0000, outPin});
      demodIn = 1'h0;
      wr(1'h0, expWord ^ 16'h0070);
      check("raw pin", 16'h0000, {15'h0000, outPin});
      wr(1'h0, expWord);
      $display("t_power done");
   endtask
   task automatic t_toggle;
      IM.slow = 1'h1;
      expectReply(16'h0813, expWord ^ 16'h0810);
      check("store image", {7'h00, expWord[15:7] ^ 9'h010}, {7'h00, nvmWrData});
      check("short reduces", 16'h0001, {15'h0000, reducedSensitivity});
      linkClosed = 1'h0;
      repeat (4) @(negedge clock);
      check("open keeps range", 16'h0000, {15'h0000, reducedSensitivity});
      linkClosed = 1'h1;
      expectReply(16'h0810, expWord);
      IM.slow = 1'h0;
      tagState = TAG_OPEN;
      expectReply(16'h8000, expWord);
      tagState = TAG_SECURED;
      accessPwdZero = 1'h1;
      expectReply(16'h8000, expWord);
      accessPwdZero = 1'h0;
      $display("t_toggle done");
   endtask
   task automatic t_refuse;
      logic got, pre;
      logic [48:0] r;
      // Bad CRC, foreign handle, reserved mask, no prior request, no frame-sync
      for (int k = 0; k < 5; k++)
      begin
         priorReqRn = (k != 3);
         cmd(((k == 2) ? 16'h0004 : 16'h8000) ^ lastRn16, handle ^ ((k == 1) ? 16'h0100 : 16'h0000),
            k != 4, (k == 0) ? 16'h0001 : 16'h0000, got, r, pre);
         check("refused", 16'h0000, {15'h0000, got});
      end
      priorReqRn = 1'h1;
      expectReply(16'h0000, expWord);
      $display("t_refuse done");
   endtask
   task automatic t_states;
      logic got, pre;
      logic [48:0] r;
      tag_state_e s[5] = '{TAG_READY, TAG_ARBITRATE, TAG_REPLY, TAG_ACKNOWLEDGED, TAG_KILLED};
      for (int k = 0; k < 5; k++)
      begin
         tagState = s[k];
         arbSeen = 0;
         cmd(16'h8000 ^ lastRn16, handle, 1'h1, 16'h0000, got, r, pre);
         check("silent", 16'h0000, {15'h0000, got});
         check("fallback", {15'h0000, k inside {1, 2, 3}}, arbSeen[15:0]);
      end
      tagState = TAG_SECURED;
      nvmBad = 1'h1;
      cmd(16'h8000 ^ lastRn16, handle, 1'h1, 16'h0000, got, r, pre);
      check("error reply", 16'h0001, {15'h0000, got});
      check("plain preamble", 16'h0000, {15'h0000, pre});
      nvmBad = 1'h0;
      $display("t_states done");
   endtask
   initial
   begin
      repeat (50000) @(posedge clock);
      err_total++;
      end_of_test();
   end
   initial
   begin
      rst = 1'h1;
      tagState = TAG_SECURED;
      {priorReqRn, supplyPad, linkClosed, epcLocked} = 4'hF;
      {accessPwdZero, nvmLoad, memRead, memWrite, nvmBad, demodIn} = 6'h00;
      lastRn16 = 16'h5A3C;
      handle = 16'hC3E1;
      memAddr = 16'h0000;
      memWdata = 16'h0000;
      nvmImage = 9'h0AB;
      repeat (21) @(negedge clock);
      rst = 1'h0;
      nvmLoad = 1'h1;
      @(negedge clock);
      nvmLoad = 1'h0;
      t_power();
      t_toggle();
      t_refuse();
      t_states();
      end_of_test();
   end
endmodule
